// ---- fptab_defines.vh ----
// Purpose: constants of the fetch sequencer and table port
// Assumes: included by both design files
// Notes: offsets are word indices on the plain register port
`ifndef FPTAB_DEFINES_VH
`define FPTAB_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FPTAB_R_LATCH 4'h0
`define FPTAB_R_PTRL 4'h1
`define FPTAB_R_PTRH 4'h2
`define FPTAB_R_PTRU 4'h3
`define FPTAB_R_PCL 4'h4
`define FPTAB_R_PCH 4'h5
`define FPTAB_R_PCU 4'h6
`define FPTAB_R_STKIDX 4'h7
`define FPTAB_R_CTRL 4'h8
`define FPTAB_R_STACK_TOP_LOW 4'h9
`define FPTAB_R_STACK_TOP_HIGH 4'hA
`define FPTAB_R_STACK_TOP_UPPER 4'hB

// ----------------------------------------
// Reset values and vectors
// ----------------------------------------
`define FPTAB_CTRL_RST 8'h01
`define FPTAB_VEC_HIGH 21'h000008
`define FPTAB_VEC_LOW 21'h000018
`define FPTAB_PC_STEP 21'h000002
`define FPTAB_PHASE_RST 4'h1

// ----------------------------------------
// Decoded instruction classes
// ----------------------------------------
`define FPTAB_C_NOP 4'h0
`define FPTAB_C_JMP 4'h1
`define FPTAB_C_CALL 4'h2
`define FPTAB_C_MOVE 4'h3
`define FPTAB_C_LDPTR 4'h4
`define FPTAB_C_BRA 4'h5
`define FPTAB_C_TST 4'h6
`define FPTAB_C_TABLE_READ_OP 4'h7
`define FPTAB_C_TABLE_WRITE_OP 4'h8
`define FPTAB_C_SECOND 4'h9

// ----------------------------------------
// Table pointer update modes
// ----------------------------------------
`define FPTAB_M_KEEP 2'h0
`define FPTAB_M_POSTINC 2'h1
`define FPTAB_M_POSTDEC 2'h2
`define FPTAB_M_PREINC 2'h3
`define FPTAB_SECOND_TAG 4'hF
`endif

// ---- fptab_table.v ----
// Purpose: table pointer and table byte latch
// Assumes: start in operand phase, done in result phase
// Notes: hardware updates win over a register write in the same cycle
`timescale 1ns/1ps
`include "fptab_defines.vh"

module fptab_table (
	// Clock and reset
	input wire sys_clk_i,
	input wire rst_i,
	// Register writes
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	// Operation control
	input wire op_start_i,
	input wire op_done_i,
	input wire op_read_i,
	input wire [1:0] op_mode_i,
	// Table memory port
	output reg [20:0] tbl_addr_o,
	output reg tbl_cfg_space_o,
	output reg tbl_rd_o,
	output reg tbl_wr_o,
	output wire [7:0] tbl_wdata_o,
	input wire [15:0] tbl_rdata_i,
	// State
	output reg [7:0] table_byte_latch_o,
	output reg [21:0] table_byte_pointer_o
);

	// Low 21 bits wrap, select bit untouched
	function [21:0] fptab_step;
		input [21:0] p;
		input up;
		begin
			fptab_step = {p[21], up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001};
		end
	endfunction

	reg [21:0] eff;
	reg [21:0] next_ptr;

	// Effective address and post-access pointer
	always @* begin
		eff = (op_mode_i == `FPTAB_M_PREINC) ? fptab_step(table_byte_pointer_o, 1'b1) : table_byte_pointer_o;
		case (op_mode_i)
			`FPTAB_M_POSTINC: next_ptr = fptab_step(table_byte_pointer_o, 1'b1);
			`FPTAB_M_POSTDEC: next_ptr = fptab_step(table_byte_pointer_o, 1'b0);
			`FPTAB_M_PREINC: next_ptr = eff;
			default: next_ptr = table_byte_pointer_o;
		endcase
	end

	assign tbl_wdata_o = table_byte_latch_o;

	// Pointer, latch and memory strobes
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tbl_addr_o <= 21'h000000;
			tbl_cfg_space_o <= 1'b0;
			tbl_rd_o <= 1'b0;
			tbl_wr_o <= 1'b0;
			table_byte_latch_o <= 8'h00;
			table_byte_pointer_o <= 22'h000000;
		end else begin
			tbl_rd_o <= op_start_i & op_read_i;
			tbl_wr_o <= op_start_i & ~op_read_i;
			if (op_start_i) begin
				tbl_addr_o <= eff[20:0];
				tbl_cfg_space_o <= eff[21];
				table_byte_pointer_o <= next_ptr;
			end else if (reg_wr_i) begin
				case (reg_addr_i)
					`FPTAB_R_PTRL: table_byte_pointer_o[7:0] <= reg_wdata_i;
					`FPTAB_R_PTRH: table_byte_pointer_o[15:8] <= reg_wdata_i;
					`FPTAB_R_PTRU: table_byte_pointer_o[21:16] <= reg_wdata_i[5:0];
					default: table_byte_pointer_o <= table_byte_pointer_o;
				endcase
			end
			// Byte lane chosen by address bit 0
			if (op_done_i & op_read_i)
				table_byte_latch_o <= tbl_addr_o[0] ? tbl_rdata_i[15:8] : tbl_rdata_i[7:0];
			else if (reg_wr_i && reg_addr_i == `FPTAB_R_LATCH)
				table_byte_latch_o <= reg_wdata_i;
		end
	end

endmodule

// ---- fptab_core.v ----
// Purpose: four-phase fetch/execute sequencer with table access
// Assumes: program word valid by phase four of the fetch cycle
// Notes: executes a reduced instruction subset for sequencing
//
// Function
// - input clock divided by four into four one-hot phases per cycle.
// - counter advances in phase one; fetched word latched in phase four.
// - fetch of next overlaps execute of current, one per cycle.
// - counter-changing instructions flush the prefetched word, costing one extra cycle.
// - operand read in phase two, destination write in phase four.
// - program memory byte addressed, instruction low byte at even address.
// - counter steps by two bytes, bit zero always zero.
// - absolute jump and call load word address into counter bits 20..1.
// - relative branch offset counts words, scaled to bytes.
// - second word has top nibble all ones, twelve literal bits.
// - lone second word is a no-operation; after first word it is consumed.
// - enabled interrupt wake loads high or low interrupt vector.
// - interrupt wake pushes counter to stack top, advances stack index.
// - eight-bit table latch holds each byte moved, one at a time.
// - table pointer is 22 bits from upper, high and low bytes.
// - top pointer bit steers access to identification and configuration space.
// - automatic pointer updates touch only the low 21 bits.
// - modes are keep, post-increment, post-decrement, pre-increment.
// - table read copies addressed program byte into the latch.
// - address bit zero selects high or low byte of the word.
`timescale 1ns/1ps
`include "fptab_defines.vh"

module fptab_core (
	// Clock and reset
	input wire sys_clk_i,
	input wire rst_i,
	// Register port
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// Program memory fetch port
	output reg [20:0] pm_addr_o,
	output reg pm_rd_o,
	input wire [15:0] pm_word_i,
	// Table memory port
	output wire [20:0] tbl_addr_o,
	output wire tbl_cfg_space_o,
	output wire tbl_rd_o,
	output wire tbl_wr_o,
	output wire [7:0] tbl_wdata_o,
	input wire [15:0] tbl_rdata_i,
	// Data memory port
	output reg [11:0] dm_addr_o,
	output reg dm_rd_o,
	input wire [7:0] dm_rdata_i,
	output reg dm_wr_o,
	output reg [7:0] dm_wdata_o,
	// Interrupt wake
	input wire wake_irq_i,
	input wire irq_high_i,
	input wire high_priority_global_enable_i,
	input wire low_priority_global_enable_i,
	// Status
	output reg [3:0] phase_o,
	output reg [15:0] instruction_latch_o,
	output reg [20:0] program_counter_o,
	output reg [20:0] stack_top_o,
	output reg [4:0] stack_index_o,
	output reg stack_push_o
);

	// ----------------------------------------
	// Decode helper
	// ----------------------------------------
	function [3:0] fptab_class;
		input [15:0] w;
		begin
			if (w[15:12] == `FPTAB_SECOND_TAG)
				fptab_class = `FPTAB_C_SECOND;
			else if (w[15:8] == 8'hEF)
				fptab_class = `FPTAB_C_JMP;
			else if (w[15:9] == 7'h76)
				fptab_class = `FPTAB_C_CALL;
			else if (w[15:12] == 4'hC)
				fptab_class = `FPTAB_C_MOVE;
			else if (w[15:6] == 10'h3B8)
				fptab_class = `FPTAB_C_LDPTR;
			else if (w[15:11] == 5'h1A)
				fptab_class = `FPTAB_C_BRA;
			else if (w[15:9] == 7'h33)
				fptab_class = `FPTAB_C_TST;
			else if (w[15:2] == 14'h0002)
				fptab_class = `FPTAB_C_TABLE_READ_OP;
			else if (w[15:2] == 14'h0003)
				fptab_class = `FPTAB_C_TABLE_WRITE_OP;
			else
				fptab_class = `FPTAB_C_NOP;
		end
	endfunction

	// ----------------------------------------
	// Internal state
	// ----------------------------------------
	reg [7:0] ctrl;
	reg latch_valid;
	reg second_pending;
	reg [3:0] pending_class;
	reg [7:0] first_literal;
	reg [7:0] operand;
	reg irq_pending;
	wire run;
	wire q1;
	wire q2;
	wire q3;
	wire q4;
	wire [3:0] cls;
	wire exec_tbl;
	wire [7:0] latch_byte;
	wire [21:0] ptr;
	wire irq_take;
	wire [20:0] irq_vector;
	wire lone_second;
	wire take_second;
	reg [20:0] next_pc;
	reg flush;
	reg push;
	reg [20:0] push_value;

	assign run = ctrl[0];
	assign q1 = phase_o[0];
	assign q2 = phase_o[1];
	assign q3 = phase_o[2];
	assign q4 = phase_o[3];
	assign cls = fptab_class(instruction_latch_o);
	assign exec_tbl = latch_valid & ((cls == `FPTAB_C_TABLE_READ_OP) | (cls == `FPTAB_C_TABLE_WRITE_OP));
	assign take_second = latch_valid & second_pending & (cls == `FPTAB_C_SECOND);
	assign lone_second = latch_valid & ~second_pending & (cls == `FPTAB_C_SECOND);
	// Wake never splits a two-word instruction
	assign irq_take = irq_pending & ~second_pending &
		(high_priority_global_enable_i | low_priority_global_enable_i);
	assign irq_vector = (irq_high_i & high_priority_global_enable_i) ? `FPTAB_VEC_HIGH : `FPTAB_VEC_LOW;

	// ----------------------------------------
	// Table pointer and latch
	// ----------------------------------------
	fptab_table u_table (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.op_start_i(exec_tbl & q2 & run),
		.op_done_i(exec_tbl & q4 & run),
		.op_read_i(cls == `FPTAB_C_TABLE_READ_OP),
		.op_mode_i(instruction_latch_o[1:0]),
		.tbl_addr_o(tbl_addr_o),
		.tbl_cfg_space_o(tbl_cfg_space_o),
		.tbl_rd_o(tbl_rd_o),
		.tbl_wr_o(tbl_wr_o),
		.tbl_wdata_o(tbl_wdata_o),
		.tbl_rdata_i(tbl_rdata_i),
		.table_byte_latch_o(latch_byte),
		.table_byte_pointer_o(ptr)
	);

	// ----------------------------------------
	// Phase generator
	// ----------------------------------------
	// One-hot ring, holds while stopped so no phase is half done
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			phase_o <= `FPTAB_PHASE_RST;
		else if (run)
			phase_o <= {phase_o[2:0], phase_o[3]};
	end

	// ----------------------------------------
	// Execute-cycle resolution in phase four
	// ----------------------------------------
	always @* begin
		next_pc = program_counter_o;
		flush = 1'b0;
		push = 1'b0;
		push_value = program_counter_o;
		if (irq_take) begin
			next_pc = irq_vector;
			flush = 1'b1;
			push = 1'b1;
		end else if (take_second) begin
			if (pending_class == `FPTAB_C_JMP || pending_class == `FPTAB_C_CALL) begin
				next_pc = {instruction_latch_o[11:0], first_literal, 1'b0};
				flush = 1'b1;
				push = (pending_class == `FPTAB_C_CALL);
				// Counter is one word past the word after the call
				push_value = program_counter_o - `FPTAB_PC_STEP;
			end
		end else if (lone_second) begin
			// Orphaned second word runs as a no-operation, counter untouched
			next_pc = program_counter_o;
		end else if (latch_valid && cls == `FPTAB_C_BRA) begin
			// Counter already sits two words past the branch
			next_pc = program_counter_o - `FPTAB_PC_STEP +
				{{9{instruction_latch_o[10]}}, instruction_latch_o[10:0], 1'b0};
			flush = 1'b1;
		end
	end

	// ----------------------------------------
	// Fetch and counter
	// ----------------------------------------
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			program_counter_o <= 21'h000000;
			pm_addr_o <= 21'h000000;
			pm_rd_o <= 1'b0;
			instruction_latch_o <= 16'h0000;
			latch_valid <= 1'b0;
		end else begin
			pm_rd_o <= run & q1;
			if (run & q1) begin
				pm_addr_o <= program_counter_o;
				program_counter_o <= program_counter_o + `FPTAB_PC_STEP;
			end
			if (run & q4) begin
				instruction_latch_o <= pm_word_i;
				program_counter_o <= {next_pc[20:1], 1'b0};
				// Discarded prefetch, or a skip taken
				latch_valid <= ~flush & ~(latch_valid & cls == `FPTAB_C_TST & operand == 8'h00);
			end
		end
	end

	// ----------------------------------------
	// Two-word sequencing
	// ----------------------------------------
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			second_pending <= 1'b0;
			pending_class <= `FPTAB_C_NOP;
			first_literal <= 8'h00;
		end else if (run & q4) begin
			second_pending <= 1'b0;
			if (latch_valid && ~irq_take && (cls == `FPTAB_C_JMP || cls == `FPTAB_C_CALL ||
				cls == `FPTAB_C_MOVE || cls == `FPTAB_C_LDPTR)) begin
				second_pending <= 1'b1;
				pending_class <= cls;
				first_literal <= instruction_latch_o[7:0];
			end
		end
	end

	// ----------------------------------------
	// Data memory operand and result
	// ----------------------------------------
	// Strobes registered at the edge before their phase
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dm_addr_o <= 12'h000;
			dm_rd_o <= 1'b0;
			dm_wr_o <= 1'b0;
			dm_wdata_o <= 8'h00;
			operand <= 8'h00;
		end else begin
			dm_rd_o <= 1'b0;
			dm_wr_o <= 1'b0;
			if (run & q1 & latch_valid & ~second_pending) begin
				if (cls == `FPTAB_C_TST) begin
					dm_addr_o <= {4'h0, instruction_latch_o[7:0]};
					dm_rd_o <= 1'b1;
				end else if (cls == `FPTAB_C_MOVE) begin
					dm_addr_o <= instruction_latch_o[11:0];
					dm_rd_o <= 1'b1;
				end
			end
			// Read data stands in phase three, after the strobe has already dropped
			if (run & q3 & latch_valid & ~second_pending & (cls == `FPTAB_C_TST || cls == `FPTAB_C_MOVE))
				operand <= dm_rdata_i;
			if (run & q3 & take_second & pending_class == `FPTAB_C_MOVE) begin
				dm_addr_o <= instruction_latch_o[11:0];
				dm_wdata_o <= operand;
				dm_wr_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Interrupt wake and stack
	// ----------------------------------------
	// A new wake in the taking cycle survives
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_pending <= 1'b0;
			stack_top_o <= 21'h000000;
			stack_index_o <= 5'h00;
			stack_push_o <= 1'b0;
		end else begin
			stack_push_o <= 1'b0;
			if (wake_irq_i)
				irq_pending <= 1'b1;
			else if (run & q4 & (irq_take | ~(high_priority_global_enable_i | low_priority_global_enable_i)))
				irq_pending <= 1'b0;
			if (run & q4 & push) begin
				stack_top_o <= push_value;
				stack_index_o <= stack_index_o + 5'h01;
				stack_push_o <= 1'b1;
			end else if (reg_wr_i && reg_addr_i == `FPTAB_R_STKIDX) begin
				stack_index_o <= reg_wdata_i[4:0];
			end
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			ctrl <= `FPTAB_CTRL_RST;
		else if (reg_wr_i && reg_addr_i == `FPTAB_R_CTRL)
			ctrl <= {7'h00, reg_wdata_i[0]};
	end

	// Read data valid only in the cycle after the strobe
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`FPTAB_R_LATCH: reg_rdata_o <= latch_byte;
				`FPTAB_R_PTRL: reg_rdata_o <= ptr[7:0];
				`FPTAB_R_PTRH: reg_rdata_o <= ptr[15:8];
				`FPTAB_R_PTRU: reg_rdata_o <= {2'h0, ptr[21:16]};
				`FPTAB_R_PCL: reg_rdata_o <= {program_counter_o[7:1], 1'b0};
				`FPTAB_R_PCH: reg_rdata_o <= program_counter_o[15:8];
				`FPTAB_R_PCU: reg_rdata_o <= {3'h0, program_counter_o[20:16]};
				`FPTAB_R_STKIDX: reg_rdata_o <= {3'h0, stack_index_o};
				`FPTAB_R_CTRL: reg_rdata_o <= ctrl;
				`FPTAB_R_STACK_TOP_LOW: reg_rdata_o <= stack_top_o[7:0];
				`FPTAB_R_STACK_TOP_HIGH: reg_rdata_o <= stack_top_o[15:8];
				`FPTAB_R_STACK_TOP_UPPER: reg_rdata_o <= {3'h0, stack_top_o[20:16]};
				default: reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

endmodule

// ---- fptab_assertions.sv ----
// Purpose: port timing checks of the fetch core
// Assumes: one clock, async high reset
// Notes: pushes come only from interrupt wake in this bench
`timescale 1ns/1ps
module fptab_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Fetch and memory strobes
	input wire logic [20:0] pm_addr_o,
	input wire logic pm_rd_o,
	input wire logic tbl_rd_o,
	input wire logic tbl_wr_o,
	input wire logic dm_rd_o,
	input wire logic dm_wr_o,
	// Sequencer state
	input wire logic [3:0] phase_o,
	input wire logic [15:0] instruction_latch_o,
	input wire logic [20:0] program_counter_o,
	input wire logic [20:0] stack_top_o,
	input wire logic [4:0] stack_index_o,
	input wire logic stack_push_o
);
	// ----
	// Properties
	// ----
	// One domain, so clock and reset are given once
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	property p_ring; phase_o == 4'h1 |=> phase_o == 4'h2 ##1 phase_o == 4'h4 ##1 phase_o == 4'h8 ##1 phase_o == 4'h1;
	endproperty
	a_ring: assert property (p_ring) else $error("phase ring out of order");
	property p_fetch; pm_rd_o |-> phase_o == 4'h2 && program_counter_o == pm_addr_o + 21'h2; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch not after counter step");
	property p_once; pm_rd_o |=> !pm_rd_o [*3]; endproperty
	a_once: assert property (p_once) else $error("more than one fetch per cycle");
	property p_align; !program_counter_o[0] && !pm_addr_o[0] && !stack_top_o[0]; endproperty
	a_align: assert property (p_align) else $error("odd program address");
	property p_latch; $changed(instruction_latch_o) |-> phase_o == 4'h1; endproperty
	a_latch: assert property (p_latch) else $error("word latched off phase four");
	property p_dmrd; dm_rd_o |-> phase_o == 4'h2; endproperty
	a_dmrd: assert property (p_dmrd) else $error("operand read off phase two");
	property p_dmwr; dm_wr_o |-> phase_o == 4'h8; endproperty
	a_dmwr: assert property (p_dmwr) else $error("result write off phase four");
	property p_tbl; (tbl_rd_o || tbl_wr_o) |-> phase_o == 4'h4 && !(tbl_rd_o && tbl_wr_o); endproperty
	a_tbl: assert property (p_tbl) else $error("table access misplaced");
	property p_push; stack_push_o |-> phase_o == 4'h1 && stack_index_o == $past(stack_index_o) + 5'h1
		&& (program_counter_o == 21'h8 || program_counter_o == 21'h18); endproperty
	a_push: assert property (p_push) else $error("wake push without vector");
endmodule
bind fptab_core fptab_checker chk_u (.sys_clk_i, .rst_i, .pm_addr_o, .pm_rd_o, .tbl_rd_o, .tbl_wr_o,
	.dm_rd_o, .dm_wr_o, .phase_o, .instruction_latch_o, .program_counter_o, .stack_top_o,
	.stack_index_o, .stack_push_o);

// ---- fptab_mem_model.sv ----
// Purpose: program, table and data memory beside the fetch core
// Assumes: answers follow the core's phase pulses
// Notes: idle outputs toggle so stale data never passes for fresh
`timescale 1ns/1ps
module fptab_mem_model (
	// Clock
	input wire logic sys_clk_i,
	// Fetch port
	input wire logic [20:0] pm_addr_i,
	input wire logic pm_rd_i,
	output logic [15:0] pm_word_o,
	// Table port
	input wire logic [20:0] tbl_addr_i,
	input wire logic tbl_cfg_i,
	input wire logic tbl_rd_i,
	output logic [15:0] tbl_rdata_o,
	// Data port
	input wire logic [11:0] dm_addr_i,
	input wire logic dm_rd_i,
	input wire logic dm_wr_i,
	input wire logic [7:0] dm_wdata_i,
	output logic [7:0] dm_rdata_o
);
	logic [15:0] pm [0:63];
	logic [7:0] dm [0:4095];
	logic [7:0] w;
	logic pm_hold;
	// ----
	// Behaviour
	// ----
	// Blank image reads as no-operation words
	initial begin
		foreach (pm[i]) pm[i] = 16'h0000;
		pm_word_o = 16'h0000;
		tbl_rdata_o = 16'h0000;
		dm_rdata_o = 8'h00;
		pm_hold = 1'b0;
	end
	assign w = tbl_addr_i[8:1];
	// Word held for phases three and four only; small image, upper bits wrap
	always @(posedge sys_clk_i) begin
		pm_hold <= pm_rd_i;
		if (pm_rd_i) pm_word_o <= pm[pm_addr_i[6:1]];
		else if (!pm_hold) pm_word_o <= ~pm_word_o;
		if (tbl_rd_i) tbl_rdata_o <= tbl_cfg_i ? {w ^ 8'h96, w ^ 8'h3C} : {w ^ 8'h5A, w ^ 8'h33};
		else tbl_rdata_o <= ~tbl_rdata_o;
		if (dm_rd_i) dm_rdata_o <= dm[dm_addr_i];
		else dm_rdata_o <= ~dm_rdata_o;
		if (dm_wr_i) dm[dm_addr_i] <= dm_wdata_i;
	end
endmodule

// ---- tb_top.sv ----
// Purpose: self-checking bench of the fetch core
// Assumes: memory model answers fetch, table and data ports
// Notes: program image is loaded into the model just after time zero
`timescale 1ns/1ps
`include "fptab_defines.vh"
module tb_top;
	// ----
	// Signals
	// ----
	logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, pm_rd_o, tbl_cfg_space_o, tbl_rd_o, tbl_wr_o, dm_rd_o;
	logic dm_wr_o, wake_irq_i, irq_high_i, high_priority_global_enable_i, low_priority_global_enable_i;
	logic stack_push_o;
	logic [3:0] reg_addr_i, phase_o;
	logic [4:0] stack_index_o;
	logic [7:0] reg_wdata_i, reg_rdata_o, tbl_wdata_o, dm_rdata_i, dm_wdata_o;
	logic [11:0] dm_addr_o;
	logic [15:0] pm_word_i, tbl_rdata_i, instruction_latch_o;
	logic [20:0] pm_addr_o, tbl_addr_o, program_counter_o, stack_top_o;
	logic [1:0] rd_d = 2'h0;
	int err_total = 0;
	int comparisons = 0;
	logic [20:0] fq[$];
	logic [21:0] ta[$], tw[$];
	logic [7:0] td[$];
	logic [19:0] dw[$];
	// Image: word index above, word below
	logic [21:0] prog [0:18] = '{22'h00EF10, 22'h01F000, 22'h04D7FF, 22'h0CD7FF, 22'h106610, 22'h11C011,
		22'h12F020, 22'h136611, 22'h14C011, 22'h15F022, 22'h16D003, 22'h1A0009, 22'h1B000A, 22'h1C000B,
		22'h1D0008, 22'h1E0009, 22'h1F0009, 22'h20000C, 22'h21D7FF};
	logic [20:0] fexp [0:18] = '{21'h00, 21'h02, 21'h04, 21'h20, 21'h22, 21'h24, 21'h26, 21'h28, 21'h2A,
		21'h2C, 21'h2E, 21'h34, 21'h36, 21'h38, 21'h3A, 21'h3C, 21'h3E, 21'h40, 21'h42};
	logic [21:0] taexp [0:5] = '{22'h3FFFFF, 22'h200000, 22'h200000, 22'h200000, 22'h200000, 22'h200001};
	logic [7:0] tdexp [0:5] = '{8'h69, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h96};
	// ----
	// Instances
	// ----
	fptab_core dut_u (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.pm_addr_o, .pm_rd_o, .pm_word_i, .tbl_addr_o, .tbl_cfg_space_o, .tbl_rd_o, .tbl_wr_o, .tbl_wdata_o,
		.tbl_rdata_i, .dm_addr_o, .dm_rd_o, .dm_rdata_i, .dm_wr_o, .dm_wdata_o, .wake_irq_i, .irq_high_i,
		.high_priority_global_enable_i, .low_priority_global_enable_i, .phase_o, .instruction_latch_o,
		.program_counter_o, .stack_top_o, .stack_index_o, .stack_push_o);
	fptab_mem_model mem_u (.sys_clk_i(sys_clk_i), .pm_addr_i(pm_addr_o), .pm_rd_i(pm_rd_o), .pm_word_o(pm_word_i),
		.tbl_addr_i(tbl_addr_o), .tbl_cfg_i(tbl_cfg_space_o), .tbl_rd_i(tbl_rd_o), .tbl_rdata_o(tbl_rdata_i),
		.dm_addr_i(dm_addr_o), .dm_rd_i(dm_rd_o), .dm_wr_i(dm_wr_o), .dm_wdata_i(dm_wdata_o),
		.dm_rdata_o(dm_rdata_i));
	// ----
	// Clock, monitors, watchdog
	// ----
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// Latch is sampled two edges after the table strobe, once it has settled
	always @(posedge sys_clk_i) begin
		rd_d <= {rd_d[0], tbl_rd_o};
		if (pm_rd_o) fq.push_back(pm_addr_o);
		if (tbl_rd_o) ta.push_back({tbl_cfg_space_o, tbl_addr_o});
		if (tbl_wr_o) tw.push_back({tbl_cfg_space_o, tbl_addr_o});
		if (rd_d[1]) td.push_back(tbl_wdata_o);
		if (dm_wr_o) dw.push_back({dm_addr_o, dm_wdata_o});
	end
	// Whole run is a few hundred cycles
	initial begin
		#20000;
		err_total++;
		results;
	end
	// ----
	// Tasks
	// ----
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(posedge sys_clk_i);
		chk(reg_rdata_o, e);
	endtask
	task wait_fetch(input logic [20:0] a);
		int n;
		n = 0;
		while (!(pm_rd_o === 1'b1 && pm_addr_o === a) && n < 200) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk(pm_addr_o, a);
	endtask
	task pulse_wake;
		@(posedge sys_clk_i);
		wake_irq_i <= 1'b1;
		@(posedge sys_clk_i);
		wake_irq_i <= 1'b0;
	endtask
	task results;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		rst_i = 1'b1;
		reg_addr_i = 4'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		wake_irq_i = 1'b0;
		irq_high_i = 1'b1;
		high_priority_global_enable_i = 1'b0;
		low_priority_global_enable_i = 1'b0;
		#1;
		foreach (prog[i]) mem_u.pm[prog[i][21:16]] = prog[i][15:0];
		mem_u.dm[12'h010] = 8'h00;
		mem_u.dm[12'h011] = 8'h5A;
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		wr(`FPTAB_R_PTRU, 8'hFF);
		wr(`FPTAB_R_PTRH, 8'hFF);
		wr(`FPTAB_R_PTRL, 8'hFF);
		rdc(`FPTAB_R_PTRU, 8'h3F);
		rdc(`FPTAB_R_PTRH, 8'hFF);
		rdc(`FPTAB_R_PTRL, 8'hFF);
		rdc(`FPTAB_R_LATCH, 8'h00);
		rdc(`FPTAB_R_STKIDX, 8'h00);
		wr(4'hC, 8'hA5);
		rdc(4'hC, 8'h00);
		for (int n = 0; n < 400 && fq.size() < 19; n++) @(posedge sys_clk_i);
		foreach (fexp[i]) chk(fq[i], fexp[i]);
		repeat (24) @(posedge sys_clk_i);
		chk(ta.size(), 6);
		foreach (taexp[i]) begin
			chk(ta[i], taexp[i]);
			chk(td[i], tdexp[i]);
		end
		rdc(`FPTAB_R_PTRU, 8'h20);
		rdc(`FPTAB_R_PTRH, 8'h00);
		rdc(`FPTAB_R_PTRL, 8'h02);
		rdc(`FPTAB_R_LATCH, 8'h96);
		chk(tw.size(), 1);
		chk(tw[0], 22'h200002);
		chk(dw.size(), 1);
		chk(dw[0], {12'h022, 8'h5A});
		high_priority_global_enable_i <= 1'b1;
		pulse_wake;
		wait_fetch(21'h08);
		rdc(`FPTAB_R_STKIDX, 8'h01);
		chk(stack_top_o === 21'h44 || stack_top_o === 21'h46, 1);
		high_priority_global_enable_i <= 1'b0;
		low_priority_global_enable_i <= 1'b1;
		pulse_wake;
		wait_fetch(21'h18);
		rdc(`FPTAB_R_STKIDX, 8'h02);
		chk(stack_top_o === 21'h0A || stack_top_o === 21'h0C, 1);
		low_priority_global_enable_i <= 1'b0;
		pulse_wake;
		repeat (20) @(posedge sys_clk_i);
		rdc(`FPTAB_R_STKIDX, 8'h02);
		results;
	end
endmodule
